// ===== rtl/oes_pkg.sv
// Package: constants and types for the output offset/expand scaler
`default_nettype none
package oes_pkg;
  // Data: signed 16-bit normalized, full scale = FS_CODE (10 V, RMS)
  localparam int           DW          = 16;
  localparam logic [15:0]  FS_CODE     = 16'h2710;  // 10000 = 10 V / 100 %
  localparam logic [15:0]  PCT_SCALE   = 16'h0064;  // Offset units of 1 %
  localparam logic [15:0]  OFS_LIM     = 16'h0069;  // 105 %
  localparam logic [15:0]  AUX_ONE_V   = 16'h03E8;  // Aux code for 1 V
  localparam logic [15:0]  PH_LIM      = 16'h0708;  // 180.0 deg in 0.1 deg
  // Display update rate
  localparam int           CLK_HZ      = 100000000;
  localparam int           DISP_HZ     = 512;
  localparam int           DISP_CYC    = CLK_HZ / DISP_HZ;
  localparam logic [17:0]  DISP_LAST   = 18'(DISP_CYC - 1);
  localparam int           BW_HZ       = 100000;  // Rear output bandwidth
  // Register map (word index = offset)
  localparam logic [3:0] A_X_OFS   = 4'h0;
  localparam logic [3:0] A_Y_OFS   = 4'h1;
  localparam logic [3:0] A_R_OFS   = 4'h2;
  localparam logic [3:0] A_EXPAND  = 4'h3;
  localparam logic [3:0] A_CHANNEL_ONE_CFG = 4'h4;
  localparam logic [3:0] A_STATUS  = 4'h5;
  localparam logic [3:0] A_PHASE   = 4'h6;
  localparam logic [3:0] A_DISP    = 4'h7;
  // Expand field positions in A_EXPAND
  localparam int EXP_X_LSB = 0;
  localparam int EXP_Y_LSB = 2;
  localparam int EXP_R_LSB = 4;
  typedef enum logic [1:0] {OES_EXP1, OES_EXP10, OES_EXP100} oes_exp_t;
  // Five display sources need three bits
  typedef enum logic [2:0] {OES_SRC_X, OES_SRC_R, OES_SRC_XN,
                            OES_SRC_AUX1, OES_SRC_AUX2} oes_unused_t;
endpackage
`default_nettype wire

// ===== rtl/oes_scaler.sv
// Output offset, expand, clamp, channel-one selection and ratio display
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Channel one: copy of X or display
// - Display-driven output refreshes at 512 Hz
// - Display source: X,R,noise,aux, ratios
// - Rear X/Y: filtered, offset, expanded results
// - Full scale of X/Y/R outputs is 10 V
// - Phase +-180 deg, readable by host only
// - Offset in percent, limited to 105
// - Expand by 1, 10 or 100 after offset
// - Output (s/sens - ofs) x expand, clamped
// - X/Y settings never touch R or phase
// - Y settings only from remote interface
// - Displays include the offset
// - Offset indicator for nonzero offset
// - Display shows value minus offset, unexpanded
// - Expand indicator for nonzero expand code
// - Ratio display percent, clamped to 100
// - Ratio indicator when ratio shown
// - Ratio output: percent times 10 V
// - All values are RMS
module oes_scaler (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        clk_en_i,
  input  wire logic [15:0] x_i,
  input  wire logic [15:0] y_i,
  input  wire logic [15:0] r_i,
  input  wire logic [15:0] xn_i,
  input  wire logic [15:0] aux1_i,
  input  wire logic [15:0] aux2_i,
  input  wire logic [15:0] phase_i,
  input  wire logic        panel_we_i,
  input  wire logic [3:0]  panel_addr_i,
  input  wire logic [15:0] panel_wdata_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  output logic [15:0]      x_out_o,
  output logic [15:0]      y_out_o,
  output logic [15:0]      r_out_o,
  output logic [15:0]      channel_one_out_o,
  output logic [15:0]      channel_one_disp_o,
  output logic             ofs_ind_o,
  output logic             exp_ind_o,
  output logic             ratio_ind_o
);

  // Signed full-scale helpers
  localparam logic signed [31:0] FS  = 32'(oes_pkg::FS_CODE);
  localparam logic signed [31:0] PCT = 32'(oes_pkg::PCT_SCALE);

  function automatic logic signed [31:0] clamp_fs(input logic signed [31:0] v);
    if (v > FS)
      clamp_fs = FS;
    else if (v < -FS)
      clamp_fs = -FS;
    else
      clamp_fs = v;
  endfunction

  function automatic logic signed [31:0] exp_mul(input logic signed [31:0] v,
                                                 input logic [1:0] e);
    case (e)
      oes_pkg::OES_EXP10:  exp_mul = v * 32'sd10;
      oes_pkg::OES_EXP100: exp_mul = v * 32'sd100;
      default:             exp_mul = v;
    endcase
  endfunction

  // Offset in percent converted to full-scale codes
  function automatic logic signed [31:0] ofs_code(input logic signed [15:0] p);
    ofs_code = (32'(p) * FS) / PCT;
  endfunction

  function automatic logic signed [15:0] ofs_lim(input logic [15:0] w);
    logic signed [15:0] s;
    s = $signed(w);
    if (s > $signed(oes_pkg::OFS_LIM))
      ofs_lim = $signed(oes_pkg::OFS_LIM);
    else if (s < -$signed(oes_pkg::OFS_LIM))
      ofs_lim = -$signed(oes_pkg::OFS_LIM);
    else
      ofs_lim = s;
  endfunction

  // Settings
  logic signed [15:0] x_ofs_r;
  logic signed [15:0] y_ofs_r;
  logic signed [15:0] r_ofs_r;
  logic [5:0]         exp_r;
  logic               channel_one_sel_r;
  logic [2:0]         src_r;
  logic [1:0]         div_r;
  logic [17:0]        tick_cnt_r;

  // Panel may write X, R, expand X/R and channel one setup but never Y
  wire panel_ok = panel_we_i && (panel_addr_i != oes_pkg::A_Y_OFS);
  wire host_wr  = reg_wr_i;
  wire any_wr   = host_wr || panel_ok;
  wire [3:0]  w_addr = host_wr ? reg_addr_i : panel_addr_i;
  wire [15:0] w_data = host_wr ? reg_wdata_i : panel_wdata_i;
  // Panel expand write keeps Y expand bits
  wire [5:0]  exp_nxt = host_wr ? w_data[5:0]
                      : {w_data[5:4], exp_r[3:2], w_data[1:0]};

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      x_ofs_r        <= '0;
      y_ofs_r        <= '0;
      r_ofs_r        <= '0;
      exp_r          <= '0;
      channel_one_sel_r <= 1'b0;
      src_r          <= '0;
      div_r          <= '0;
    end
    else if (clk_en_i && any_wr)
    begin
      case (w_addr)
        oes_pkg::A_X_OFS: x_ofs_r <= ofs_lim(w_data);
        oes_pkg::A_Y_OFS: y_ofs_r <= ofs_lim(w_data);
        oes_pkg::A_R_OFS: r_ofs_r <= ofs_lim(w_data);
        oes_pkg::A_EXPAND: exp_r  <= exp_nxt;
        oes_pkg::A_CHANNEL_ONE_CFG:
        begin
          channel_one_sel_r <= w_data[0];
          src_r          <= (w_data[3:1] > 3'h4) ? 3'h0 : w_data[3:1];
          div_r          <= (w_data[5:4] == 2'h3) ? 2'h0 : w_data[5:4];
        end
        default: ;
      endcase
    end
  end

  wire [1:0] ex_x = exp_r[oes_pkg::EXP_X_LSB +: 2];
  wire [1:0] ex_y = exp_r[oes_pkg::EXP_Y_LSB +: 2];
  wire [1:0] ex_r = exp_r[oes_pkg::EXP_R_LSB +: 2];

  // Offset percentages are independent of sensitivity: inputs already normalized
  wire signed [31:0] x_diff = 32'($signed(x_i)) - ofs_code(x_ofs_r);
  wire signed [31:0] y_diff = 32'($signed(y_i)) - ofs_code(y_ofs_r);
  // R uses its own offset and expand only
  wire signed [31:0] r_diff = 32'($signed(r_i)) - ofs_code(r_ofs_r);
  wire signed [31:0] x_sc = clamp_fs(exp_mul(x_diff, ex_x));
  wire signed [31:0] y_sc = clamp_fs(exp_mul(y_diff, ex_y));
  wire signed [31:0] r_sc = clamp_fs(exp_mul(r_diff, ex_r));

  // Display value: minus offset, not expanded (resolution only)
  wire signed [31:0] src_val =
    (src_r == 3'h0) ? x_diff :
    (src_r == 3'h1) ? r_diff :
    (src_r == 3'h2) ? 32'($signed(xn_i)) :
    (src_r == 3'h3) ? 32'($signed(aux1_i)) :
                      32'($signed(aux2_i));
  wire [1:0] src_exp = (src_r == 3'h0) ? ex_x : (src_r == 3'h1) ? ex_r : 2'h0;
  wire signed [31:0] src_exp_val =
    (src_r == 3'h0) ? x_sc : (src_r == 3'h1) ? r_sc : src_val;
  wire is_ratio = (div_r != 2'h0);
  wire signed [31:0] den = 32'($signed((div_r == 2'h1) ? aux1_i : aux2_i));
  // Ratio % code: expanded normalized x 100% / aux volts, FS code = 100 %
  wire signed [31:0] ratio_raw =
    (den == 32'sd0) ? FS : (src_exp_val * $signed(32'(oes_pkg::AUX_ONE_V))) / den;
  wire signed [31:0] disp_val = is_ratio ? clamp_fs(ratio_raw) : clamp_fs(src_val);
  wire src_has_ofs = ((src_r == 3'h0) && (x_ofs_r != 16'sh0000))
                  || ((src_r == 3'h1) && (r_ofs_r != 16'sh0000));
  wire src_has_exp = ((src_r == 3'h0) || (src_r == 3'h1)) && (src_exp != 2'h0);

  // 512 Hz refresh tick for display-following output
  wire tick = (tick_cnt_r == oes_pkg::DISP_LAST);

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tick_cnt_r <= '0;
    else if (clk_en_i)
      tick_cnt_r <= tick ? 18'h00000 : tick_cnt_r + 18'h00001;
  end

  // Rear outputs follow every sample (bandwidth bounded by sample rate)
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      x_out_o     <= '0;
      y_out_o     <= '0;
      r_out_o     <= '0;
      channel_one_out_o  <= '0;
      channel_one_disp_o <= '0;
      ofs_ind_o   <= 1'b0;
      exp_ind_o   <= 1'b0;
      ratio_ind_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      x_out_o <= x_sc[15:0];
      y_out_o <= y_sc[15:0];
      r_out_o <= r_sc[15:0];
      ofs_ind_o   <= src_has_ofs;
      exp_ind_o   <= src_has_exp;
      ratio_ind_o <= is_ratio;
      if (tick)
        channel_one_disp_o <= disp_val[15:0];
      if (!channel_one_sel_r)
        channel_one_out_o <= x_sc[15:0];
      else if (tick)
        // Ratio percent maps onto 10 V full scale; plain X/R uses expanded path
        channel_one_out_o <= is_ratio ? disp_val[15:0] : src_exp_val[15:0];
    end
  end

  // Host-only readback; phase is passed through limited to +-180 deg
  wire signed [15:0] ph_s = $signed(phase_i);
  wire [15:0] ph_lim = (ph_s > $signed(oes_pkg::PH_LIM)) ? oes_pkg::PH_LIM :
                       (ph_s < -$signed(oes_pkg::PH_LIM)) ? 16'(-$signed(oes_pkg::PH_LIM)) :
                       phase_i;
  wire [15:0] rd_mux =
    (reg_addr_i == oes_pkg::A_X_OFS)   ? x_ofs_r :
    (reg_addr_i == oes_pkg::A_Y_OFS)   ? y_ofs_r :
    (reg_addr_i == oes_pkg::A_R_OFS)   ? r_ofs_r :
    (reg_addr_i == oes_pkg::A_EXPAND)  ? {10'h000, exp_r} :
    (reg_addr_i == oes_pkg::A_CHANNEL_ONE_CFG) ? {10'h000, div_r, src_r, channel_one_sel_r} :
    (reg_addr_i == oes_pkg::A_STATUS)  ? {13'h0000, ratio_ind_o, exp_ind_o, ofs_ind_o} :
    (reg_addr_i == oes_pkg::A_PHASE)   ? ph_lim :
    (reg_addr_i == oes_pkg::A_DISP)    ? channel_one_disp_o : 16'h0000;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= '0;
    else if (clk_en_i)
      reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
  end

  // Assertions
  clamp_pos_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $signed(x_out_o) <= $signed(oes_pkg::FS_CODE) && $signed(x_out_o) >= -$signed(oes_pkg::FS_CODE))
    else $error("x output beyond full scale");
  y_panel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (panel_we_i && !reg_wr_i && panel_addr_i == oes_pkg::A_Y_OFS && clk_en_i) |=> $stable(y_ofs_r))
    else $error("panel changed y offset");
  ofs_range_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    x_ofs_r <= $signed(oes_pkg::OFS_LIM) && x_ofs_r >= -$signed(oes_pkg::OFS_LIM))
    else $error("x offset out of range");
  ch1_copy_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (clk_en_i && !channel_one_sel_r) |=> (channel_one_out_o == $past(x_sc[15:0])))
    else $error("channel one not copying x");
  disp_rate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!tick && clk_en_i) |=> $stable(channel_one_disp_o))
    else $error("display updated off tick");
  ratio_ind_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    clk_en_i |=> (ratio_ind_o == $past(is_ratio)))
    else $error("ratio indicator wrong");
  ofs_ind_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (clk_en_i && src_r == 3'h0 && x_ofs_r == 16'sh0000) |=> !ofs_ind_o)
    else $error("offset indicator without offset");
  exp_ind_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (clk_en_i && src_r == 3'h2) |=> !exp_ind_o)
    else $error("expand indicator on noise source");
  phase_rng_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $signed(ph_lim) <= $signed(oes_pkg::PH_LIM))
    else $error("phase out of range");
  cov_ratio_c: cover property (@(posedge sys_clk_i) is_ratio && tick);
  cov_clamp_c: cover property (@(posedge sys_clk_i) x_out_o == oes_pkg::FS_CODE);
  y_clamp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $signed(y_out_o) <= $signed(oes_pkg::FS_CODE) && $signed(y_out_o) >= -$signed(oes_pkg::FS_CODE))
    else $error("y output beyond full scale");
  r_clamp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $signed(r_out_o) <= $signed(oes_pkg::FS_CODE) && $signed(r_out_o) >= -$signed(oes_pkg::FS_CODE))
    else $error("r output beyond full scale");
  // Display-following output must not track samples between refresh ticks
  chan_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (clk_en_i && channel_one_sel_r && !tick) |=> $stable(channel_one_out_o))
    else $error("channel one output moved off tick");
  clk_freeze_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !clk_en_i |=> $stable(x_out_o))
    else $error("x output moved while clock enable low");
  cov_disp_c:  cover property (@(posedge sys_clk_i) channel_one_sel_r && tick);
  cov_panel_c: cover property (@(posedge sys_clk_i) panel_ok && clk_en_i);

endmodule
`default_nettype wire

// ===== sim/oes_panel_user.sv
// Front-panel user model: issues single-cycle panel writes
`timescale 1ns/1ns
`default_nettype none
module oes_panel_user (
  input  wire logic        sys_clk_i,
  output logic             panel_we_o,
  output logic [3:0]       panel_addr_o,
  output logic [15:0]      panel_wdata_o
);
  initial
  begin
    panel_we_o    = 1'b0;
    panel_addr_o  = 4'hF;
    panel_wdata_o = 16'h0000;
  end

  task automatic press(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    panel_we_o    <= 1'b1;
    panel_addr_o  <= a;
    panel_wdata_o <= d;
    @(posedge sys_clk_i);
    panel_we_o    <= 1'b0;
    // Released lines carry the inverse so stale values never look valid
    panel_addr_o  <= ~a;
    panel_wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Testbench for the output offset/expand scaler
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, (ex), (got)); end end
module tb;
  logic        sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, panel_we_i;
  logic [3:0]  reg_addr_i, panel_addr_i;
  logic [15:0] x_i, y_i, r_i, xn_i, aux1_i, aux2_i, phase_i, reg_wdata_i, panel_wdata_i;
  logic [15:0] reg_rdata_o, x_out_o, y_out_o, r_out_o, channel_one_out_o, channel_one_disp_o;
  logic [15:0] held;
  logic        ofs_ind_o, exp_ind_o, ratio_ind_o;
  int          n_fail, n_tests;
  logic [15:0] exp_tab [4] = '{16'h000A, 16'h0064, 16'h03E8, 16'h000A};

  oes_panel_user u_panel (.sys_clk_i(sys_clk_i), .panel_we_o(panel_we_i),
    .panel_addr_o(panel_addr_i), .panel_wdata_o(panel_wdata_i));
  oes_scaler dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1), .x_i(x_i),
    .y_i(y_i), .r_i(r_i), .xn_i(xn_i), .aux1_i(aux1_i), .aux2_i(aux2_i), .phase_i(phase_i),
    .panel_we_i(panel_we_i), .panel_addr_i(panel_addr_i), .panel_wdata_i(panel_wdata_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .x_out_o(x_out_o), .y_out_o(y_out_o),
    .r_out_o(r_out_o), .channel_one_out_o(channel_one_out_o),
    .channel_one_disp_o(channel_one_disp_o),
    .ofs_ind_o(ofs_ind_o), .exp_ind_o(exp_ind_o), .ratio_ind_o(ratio_ind_o));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] ex);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata_o)
  endtask

  // Outputs land one cycle after a sample; three cycles leave margin
  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_fail++;
    wrap_up();
  end

  initial
  begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {x_i, y_i, r_i, xn_i, phase_i} = '0;
    aux1_i = 16'h07D0;
    aux2_i = 16'h03E8;
    rstn_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    #1;
    `CHK("x_out reset", 16'h0000, x_out_o)
    rd_chk("unmapped", 4'h8, 16'h0000);
    wr(oes_pkg::A_X_OFS, 16'h00C8);
    rd_chk("x ofs hi", oes_pkg::A_X_OFS, oes_pkg::OFS_LIM);
    wr(oes_pkg::A_X_OFS, 16'hFF38);
    rd_chk("x ofs lo", oes_pkg::A_X_OFS, 16'hFF97);
    x_i <= 16'h1F40;
    r_i <= 16'h0FA0;
    y_i <= 16'h1770;
    wr(oes_pkg::A_X_OFS, 16'h0032);
    wr(oes_pkg::A_Y_OFS, 16'h0014);
    settle();
    `CHK("x_out ofs", 16'h0BB8, x_out_o)
    `CHK("channel one copy", 16'h0BB8, channel_one_out_o)
    `CHK("r_out", 16'h0FA0, r_out_o)
    `CHK("y_out", 16'h0FA0, y_out_o)
    `CHK("ofs ind", 1'b1, ofs_ind_o)
    x_i <= 16'h1392;
    for (int k = 0; k < 4; k++)
    begin
      wr(oes_pkg::A_EXPAND, 16'(k));
      settle();
      `CHK("x expand", exp_tab[k], x_out_o)
    end
    wr(oes_pkg::A_EXPAND, 16'h0001);
    x_i <= 16'h1F40;
    settle();
    `CHK("clamp hi", oes_pkg::FS_CODE, x_out_o)
    `CHK("exp ind", 1'b1, exp_ind_o)
    x_i <= 16'h0000;
    settle();
    `CHK("clamp lo", 16'hD8F0, x_out_o)
    wr(oes_pkg::A_EXPAND, 16'h0000);
    u_panel.press(oes_pkg::A_Y_OFS, 16'h001E);
    rd_chk("panel y", oes_pkg::A_Y_OFS, 16'h0014);
    u_panel.press(oes_pkg::A_R_OFS, 16'h000A);
    rd_chk("panel r", oes_pkg::A_R_OFS, 16'h000A);
    settle();
    `CHK("r_out ofs", 16'h0BB8, r_out_o)
    phase_i <= 16'h07D0;
    rd_chk("phase hi", oes_pkg::A_PHASE, oes_pkg::PH_LIM);
    phase_i <= 16'hF830;
    rd_chk("phase lo", oes_pkg::A_PHASE, 16'hF8F8);
    wr(oes_pkg::A_CHANNEL_ONE_CFG, 16'h0010);
    settle();
    `CHK("ratio ind", 1'b1, ratio_ind_o)
    rd_chk("status", oes_pkg::A_STATUS, 16'h0005);
    `CHK("disp before tick", 16'h0000, channel_one_disp_o)
    wr(oes_pkg::A_CHANNEL_ONE_CFG, 16'h0001);
    settle();
    held = channel_one_out_o;
    x_i <= 16'h1000;
    // Display-driven output must not track samples between ticks
    for (int k = 0; k < 50; k++)
    begin
      @(posedge sys_clk_i);
      #1;
      `CHK("channel one hold", held, channel_one_out_o)
    end
    wrap_up();
  end
endmodule
`default_nettype wire
